// File: pkg/adsc_cfg.svh
// constants of the converter sequence controller
// assumes inclusion by the package and the bench only
`ifndef ADSC_CFG_SVH
`define ADSC_CFG_SVH

// register byte offsets on the apb bus
`define ADSC_OFF_MODE0 12'h000
`define ADSC_OFF_MODE1 12'h004
`define ADSC_OFF_RES0 12'h020
`define ADSC_OFF_RES7 12'h03C

// channel_mode_control fields
`define ADSC_SEL_MSB 2
`define ADSC_SEL_LSB 0
`define ADSC_SINGLE_BIT 4
`define ADSC_BUFDEPTH_BIT 5
`define ADSC_RUN_BIT 7
`define ADSC_MODE0_RST 8'h00
`define ADSC_MODE0_WMASK 8'hB7

// timing_trigger_control fields
`define ADSC_CLK_MSB 2
`define ADSC_CLK_LSB 0
`define ADSC_TRG_MSB 6
`define ADSC_TRG_LSB 4
`define ADSC_EDGE_BIT 7
`define ADSC_MODE1_RST 8'h07
`define ADSC_MODE1_WMASK 8'hF7

// trigger source codes
`define ADSC_TRG_TMR1 3'h2
`define ADSC_TRG_TMR4 3'h3
`define ADSC_TRG_EXT1 3'h4
`define ADSC_TRG_EXT4 3'h5

// conversion clock counts per code
`define ADSC_CC0 8'h08
`define ADSC_CC1 8'h10
`define ADSC_CC2 8'h14
`define ADSC_CC3 8'h18
`define ADSC_CC4 8'h1C
`define ADSC_CC5 8'h20
`define ADSC_CC6 8'h40
`define ADSC_CC7 8'h80

// bit trial: last of three steps per trial, msb index
`define ADSC_TRIAL_LAST 2'h2
`define ADSC_MSB_IDX 4'h9
`define ADSC_TRIAL_START 10'h200
`define ADSC_HW_CHANS 3'h3
`define ADSC_BUF_LAST 3'h3

`endif

// File: pkg/adsc_pkg.sv
// types of the converter sequence controller
// assumes adsc_cfg.svh on the include path
package adsc_pkg;
  `include "adsc_cfg.svh"

  typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_SAMPLE, ST_TRIAL} adsc_state_e;
  typedef enum logic [1:0] {SRC_SW, SRC_TMR, SRC_EXT} adsc_src_e;

  // signals toward the analog front end
  typedef struct packed {
    logic sampleHold;
    logic [2:0] chanSel;
    logic [9:0] dacCode;
  } adsc_afe_s;

  typedef struct packed {
    adsc_state_e st;
    logic [7:0] mode0;
    logic [7:0] mode1;
    logic [7:0] cnt;
    logic [3:0] bitIdx;
    logic [1:0] step;
    logic [9:0] trial;
    logic [2:0] chan;
    logic [2:0] done;
    logic [3:0] usedMask;
    logic [7:0][9:0] res;
    logic irq;
    logic sampleHold;
    logic [3:0] extS1;
    logic [3:0] extS2;
    logic [3:0] extS3;
    logic cmpS1;
    logic cmpS2;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } adsc_state_s;
endpackage

// File: verilog/adsc_ctrl.sv
// sequence controller of a 10-bit successive-approximation converter
// assumes an external comparator, dac and sample switch on the afe port
//
// What this block does
// - inputs four to seven convert only by software start
// - ten-bit trial register drives dac, copied to result on completion
// - completion interrupt only after all conversions of the mode
// - select input, time sample-hold, gate triggers from both mode registers
// - write to mode register 0 during conversion restarts sequence
// - select mode: field picks one of eight inputs
// - software scan of value n converts inputs zero to n
// - hardware scan: values 0..3 give one to four trigger inputs
// - bit 4 zero scan, one select
// - bit 5 zero one buffer, one four buffers, select only
// - software mode: writing run bit starts or stops, read shows busy
// - run bit clears itself when the sequence completes
// - hardware mode: trigger sets run bit, zero means waiting
// - write to mode register 1 during conversion restarts sequence
// - clock field maps to 8,16,20,24,28,32,64,128 sample clocks
// - trigger field decodes software, timer and external sources
// - edge bit picks falling or rising external trigger edges
// - four-buffer: four conversions to results zero..three, one interrupt
// - one-buffer: interrupt after each conversion into matching result
// - results read as ten low bits, upper bits zero
module adsc_ctrl
  import adsc_pkg::*;
(
  input wire logic clock, // 40 MHz system clock
  input wire logic resetn, // async reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb direction
  input wire logic [11:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error on unmapped address
  input wire logic [3:0] timerTrig, // timer_pulse_unit pulses, same clock
  input wire logic [3:0] extConvTrig, // ext_conv_trigger_n pins, async
  input wire logic cmpHigh, // comparator: input above dac, async
  output adsc_afe_s afe, // sample switch, input select, dac code
  output logic convDoneIrq // conv_done_irq, one-cycle pulse
);

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [7:0] convClocks(input logic [2:0] code);
    case (code)
      3'h0: convClocks = `ADSC_CC0;
      3'h1: convClocks = `ADSC_CC1;
      3'h2: convClocks = `ADSC_CC2;
      3'h3: convClocks = `ADSC_CC3;
      3'h4: convClocks = `ADSC_CC4;
      3'h5: convClocks = `ADSC_CC5;
      3'h6: convClocks = `ADSC_CC6;
      default: convClocks = `ADSC_CC7;
    endcase
  endfunction

  function automatic adsc_src_e srcOf(input logic [7:0] m1);
    // prohibited codes fall back to software start
    case (m1[`ADSC_TRG_MSB:`ADSC_TRG_LSB])
      `ADSC_TRG_TMR1, `ADSC_TRG_TMR4: srcOf = SRC_TMR;
      `ADSC_TRG_EXT1, `ADSC_TRG_EXT4: srcOf = SRC_EXT;
      default: srcOf = SRC_SW;
    endcase
  endfunction

  // hardware triggering only reaches the low four inputs
  function automatic logic hwArmed(input logic [7:0] m0, input logic [7:0] m1);
    // inputs four to seven stay software start
    hwArmed = (srcOf(m1) != SRC_SW) && (m0[`ADSC_SEL_MSB:`ADSC_SEL_LSB] <= `ADSC_HW_CHANS);
  endfunction

  function automatic logic [2:0] lowestHit(input logic [3:0] hits);
    lowestHit = 3'h0;
    for (int i = 3; i >= 0; i--)
    begin
      if (hits[i])
      begin
        lowestHit = 3'(i);
      end
    end
  endfunction

  adsc_state_s q;
  adsc_state_s d;

  // decoded settings
  logic [2:0] sel;
  logic singleMode;
  logic fourBuf;
  adsc_src_e src;
  logic hwMode;
  logic [2:0] lastIdx;
  logic [3:0] rawHits;
  logic [3:0] hits;
  logic apbDone;
  logic wrMode0;
  logic wrMode1;
  logic trialEnd;
  logic [9:0] keptTrial;
  logic [2:0] resIdx;
  logic mapped;
  logic [2:0] rdIdx;

  always_comb
  begin
    // mode registers steer selection and trigger gating
    sel = q.mode0[`ADSC_SEL_MSB:`ADSC_SEL_LSB];
    singleMode = q.mode0[`ADSC_SINGLE_BIT];
    // buffer depth only matters in select mode
    fourBuf = singleMode && q.mode0[`ADSC_BUFDEPTH_BIT];
    src = srcOf(q.mode1);
    hwMode = hwArmed(q.mode0, q.mode1);
    // last conversion index of the sequence
    if (singleMode)
    begin
      lastIdx = fourBuf ? `ADSC_BUF_LAST : 3'h0;
    end
    else
    begin
      lastIdx = sel;
    end
    // polarity edge from settled samples, never stage one
    rawHits = q.mode1[`ADSC_EDGE_BIT] ? (q.extS2 & ~q.extS3) : (~q.extS2 & q.extS3);
    if (src == SRC_TMR)
    begin
      rawHits = timerTrig;
    end
    // one-trigger modes listen to trigger zero only
    hits = q.mode1[`ADSC_TRG_LSB] ? rawHits : (rawHits & 4'h1);
    // hardware scan: trigger n converts input n once, n within count
    if (!singleMode)
    begin
      for (int i = 0; i < 4; i++)
      begin
        if (3'(i) > sel || q.usedMask[i])
        begin
          hits[i] = 1'b0;
        end
      end
    end
    apbDone = psel && penable && q.pready;
    mapped = (paddr == `ADSC_OFF_MODE0) || (paddr == `ADSC_OFF_MODE1)
      || (paddr >= `ADSC_OFF_RES0 && paddr <= `ADSC_OFF_RES7 && paddr[1:0] == 2'h0);
    wrMode0 = apbDone && pwrite && paddr == `ADSC_OFF_MODE0;
    wrMode1 = apbDone && pwrite && paddr == `ADSC_OFF_MODE1;
    trialEnd = (q.st == ST_TRIAL) && (q.step == `ADSC_TRIAL_LAST);
    // keep trial bit when the input sits above the dac level
    keptTrial = q.cmpS2 ? q.trial : (q.trial & ~(10'h001 << q.bitIdx));
    // four-buffer writes results zero..three; else the input's own
    resIdx = fourBuf ? q.done : q.chan;
    rdIdx = 3'(paddr[4:2]);
  end

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb
  begin
    d = q;
    d.irq = 1'b0;
    d.extS1 = extConvTrig;
    d.extS2 = q.extS1;
    d.extS3 = q.extS2;
    d.cmpS1 = cmpHigh;
    d.cmpS2 = q.cmpS1;

    // sequencer
    case (q.st)
      ST_IDLE:
      begin
        d.cnt = 8'h00;
      end
      ST_WAIT:
      begin
        if (hits != 4'h0)
        begin
          // a trigger sets the run bit and starts a conversion
          d.mode0[`ADSC_RUN_BIT] = 1'b1;
          d.chan = singleMode ? sel : lowestHit(hits);
          d.usedMask = q.usedMask | hits & (4'h1 << lowestHit(hits));
          d.cnt = 8'h00;
          d.st = ST_SAMPLE;
        end
      end
      ST_SAMPLE:
      begin
        // sample-hold lasts the selected clock count
        if (q.cnt == convClocks(q.mode1[`ADSC_CLK_MSB:`ADSC_CLK_LSB]) - 8'h01)
        begin
          d.st = ST_TRIAL;
          d.bitIdx = `ADSC_MSB_IDX;
          d.step = 2'h0;
          d.trial = `ADSC_TRIAL_START;
        end
        else
        begin
          d.cnt = q.cnt + 8'h01;
        end
      end
      ST_TRIAL:
      begin
        // two cycles let the comparator answer cross its synchroniser
        d.step = q.step + 2'h1;
        if (trialEnd)
        begin
          d.step = 2'h0;
          if (q.bitIdx == 4'h0)
          begin
            // result copied from the trial register
            d.res[resIdx] = keptTrial;
            d.trial = keptTrial;
            d.cnt = 8'h00;
            d.done = q.done + 3'h1;
            if (q.done == lastIdx)
            begin
              // interrupt only after the whole sequence
              // in one-buffer select mode that is every conversion
              d.irq = 1'b1;
              d.mode0[`ADSC_RUN_BIT] = 1'b0;
              d.done = 3'h0;
              d.usedMask = 4'h0;
              d.st = hwMode ? ST_WAIT : ST_IDLE;
            end
            else if (hwMode)
            begin
              // next conversion waits for its own trigger
              d.st = ST_WAIT;
            end
            else
            begin
              // software scan walks inputs zero to n in order
              // select mode repeats the selected input
              d.chan = singleMode ? sel : q.chan + 3'h1;
              d.st = ST_SAMPLE;
            end
          end
          else
          begin
            d.trial = keptTrial | (10'h001 << (q.bitIdx - 4'h1));
            d.bitIdx = q.bitIdx - 4'h1;
          end
        end
      end
      default:
      begin
        d.st = ST_IDLE;
      end
    endcase

    // mode writes abort and restart; they win over the sequencer
    if (wrMode0 || wrMode1)
    begin
      // restart after a write to mode register 0
      if (wrMode0)
      begin
        // whole byte written; bit updates arrive as byte writes
        d.mode0 = pwdata[7:0] & `ADSC_MODE0_WMASK;
      end
      // restart after a write to mode register 1
      if (wrMode1)
      begin
        d.mode1 = pwdata[7:0] & `ADSC_MODE1_WMASK;
      end
      d.cnt = 8'h00;
      d.done = 3'h0;
      d.usedMask = 4'h0;
      d.step = 2'h0;
      d.chan = d.mode0[`ADSC_SINGLE_BIT] ? d.mode0[`ADSC_SEL_MSB:`ADSC_SEL_LSB] : 3'h0;
      if (hwArmed(d.mode0, d.mode1))
      begin
        // zero means waiting for a trigger
        d.mode0[`ADSC_RUN_BIT] = 1'b0;
        d.st = ST_WAIT;
      end
      else
      begin
        // written one starts, written zero disables
        d.st = d.mode0[`ADSC_RUN_BIT] ? ST_SAMPLE : ST_IDLE;
      end
    end

    d.sampleHold = (d.st == ST_SAMPLE);
    // apb slave: ready one cycle after setup, data prepared in setup
    d.pready = psel && !penable;
    d.pslverr = psel && !penable && !mapped;
    d.prdata = 32'h0000_0000;
    if (psel && !penable && !pwrite)
    begin
      if (paddr == `ADSC_OFF_MODE0)
      begin
        d.prdata = {24'h00_0000, q.mode0};
      end
      else if (paddr == `ADSC_OFF_MODE1)
      begin
        d.prdata = {24'h00_0000, q.mode1};
      end
      else if (mapped)
      begin
        // upper bits of a result read as zero
        d.prdata = {22'h00_0000, q.res[rdIdx]};
      end
    end
  end

  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      q <= '0;
      q.mode0 <= `ADSC_MODE0_RST;
      q.mode1 <= `ADSC_MODE1_RST;
      q.st <= ST_IDLE;
    end
    else
    begin
      q <= d;
    end
  end

  assign prdata = q.prdata;
  assign pready = q.pready;
  assign pslverr = q.pslverr;
  assign convDoneIrq = q.irq;
  assign afe.sampleHold = q.sampleHold;
  assign afe.chanSel = q.chan;
  assign afe.dacCode = q.trial;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);

  sequence sSwRunWrite;
    wrMode0 && pwdata[`ADSC_RUN_BIT] && !hwArmed(pwdata[7:0], q.mode1);
  endsequence

  sequence sSampleRun;
    q.st == ST_SAMPLE && q.cnt == 8'h00 && q.mode0[`ADSC_RUN_BIT];
  endsequence

  a_sw_run_start: assert property (sSwRunWrite |=> sSampleRun)
    else $error("software run write did not start sampling");

  a_run_clears: assert property (q.irq |-> !q.mode0[`ADSC_RUN_BIT])
    else $error("run bit still set at completion");

  a_hw_high_inputs: assert property
    (q.st == ST_WAIT && hits != 4'h0 && !wrMode0 && !wrMode1 |=> q.chan <= `ADSC_HW_CHANS)
    else $error("hardware trigger reached an upper input");

  a_sample_length: assert property
    ($fell(q.st == ST_SAMPLE) && !$past(wrMode0 || wrMode1)
     |-> $past(q.cnt) == convClocks(q.mode1[`ADSC_CLK_MSB:`ADSC_CLK_LSB]) - 8'h01)
    else $error("sample phase length wrong");

  a_write_restart: assert property
    ((wrMode0 || wrMode1) && q.st != ST_IDLE |=> q.cnt == 8'h00 && q.done == 3'h0
     && q.st != ST_TRIAL)
    else $error("mode write did not restart sequence");

  a_four_buf_irq: assert property
    (q.irq && $past(fourBuf) && !$past(wrMode0 || wrMode1) |-> $past(q.done) == `ADSC_BUF_LAST)
    else $error("four-buffer interrupt before fourth conversion");

  a_irq_only_last: assert property
    (trialEnd && q.bitIdx == 4'h0 && q.done != lastIdx && !wrMode0 && !wrMode1 |=> !q.irq)
    else $error("interrupt raised mid sequence");

  a_result_upper: assert property
    (psel && !penable && !pwrite && paddr >= `ADSC_OFF_RES0 |=> q.prdata[31:10] == 22'h0)
    else $error("result upper bits not zero");

  a_select_chan: assert property
    (q.st == ST_SAMPLE && singleMode |-> q.chan == sel)
    else $error("select mode converts wrong input");

  a_edge_trigger: assert property
    (q.st == ST_WAIT && src == SRC_EXT && hits == 4'h0 && !wrMode0 && !wrMode1
     |=> q.st == ST_WAIT)
    else $error("conversion left standby without an edge");

  a_mode0_reset: assert property ($rose(resetn) |-> q.mode0 == `ADSC_MODE0_RST)
    else $error("mode register 0 reset value wrong");
endmodule

// File: verification/adsc_afe_model.sv
// analog front end model: input levels, sample capture, comparator
// assumes sampleHold is high while the selected input is sampled
module adsc_afe_model
  import adsc_pkg::*;
(
  input wire logic clock, // system clock
  input wire adsc_afe_s afe, // sample switch, input select, dac code
  input wire logic [7:0][9:0] level, // level of each analog input
  output logic cmpHigh // held level at or above the dac
);
  // --------
  // behaviour
  // --------
  logic [9:0] held = 10'h000;
  logic noise = 1'b0;
  always @(posedge clock)
  begin
    noise <= ~noise;
    if (afe.sampleHold)
      held <= level[afe.chanSel];
  end
  // compare with dac
  // output is meaningless while sampling, so it toggles
  assign cmpHigh = afe.sampleHold ? noise : (held >= afe.dacCode);
endmodule

// File: verification/adsc_sequence_controller_bench.sv
// self-checking bench of the converter sequence controller over apb
// assumes adsc_cfg.svh on the include path and the afe model beside it
`include "adsc_cfg.svh"
module adsc_sequence_controller_bench
  import adsc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // --------
  // signals
  // --------
  logic clock = 1'b0, resetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000, prdata, rdData;
  logic pready, pslverr, cmpHigh, convDoneIrq, rdErr;
  logic [3:0] timerTrig = 4'h0, extConvTrig = 4'hF;
  logic [7:0][9:0] level = '0;
  adsc_afe_s afe;
  int err_total = 0, check_count = 0, irqCnt = 0, cyc = 0, irqAt = 0, tW = 0;

  adsc_ctrl DUT (.clock(clock), .resetn(resetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .timerTrig(timerTrig),
    .extConvTrig(extConvTrig), .cmpHigh(cmpHigh), .afe(afe),
    .convDoneIrq(convDoneIrq));
  adsc_afe_model afeModel (.clock(clock), .afe(afe), .level(level), .cmpHigh(cmpHigh));

  always #12.5 clock = ~clock;
  always @(posedge clock)
  begin
    cyc <= cyc + 1;
    if (convDoneIrq === 1'b1)
    begin
      irqCnt <= irqCnt + 1;
      irqAt <= cyc;
    end
  end
  // --------
  // tasks
  // --------
  function automatic int convLen(input logic [2:0] code);
    int tab [8] = '{8, 16, 20, 24, 28, 32, 64, 128};
    return tab[code];
  endfunction

  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
    begin
      $display("All tests passed");
    end
    else
    begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic hang();
    err_total++;
    close_out();
  endtask

  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      err_total++;
      $display("MISMATCH %s exp %h got %h", nm, exp, got);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clock);
      n++;
    end
    while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1)
      hang();
    rdData = prdata;
    rdErr = pslverr;
    if (w)
      tW = cyc;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rc(input string nm, input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h00000000);
    chk(nm, rdData, exp);
  endtask

  task automatic resChk(input int i, input int src);
    rc("result", 12'(`ADSC_OFF_RES0 + 4 * i), 32'(level[src]));
  endtask

  task automatic waitIrq(input int k, input int lim);
    int n;
    n = 0;
    while (irqCnt < k && n < lim)
    begin
      @(posedge clock);
      n++;
    end
    if (irqCnt < k)
      hang();
  endtask

  task automatic quiet(input int k, input int m);
    repeat (m) @(posedge clock);
    chk("irq count", irqCnt, k);
  endtask

  // k conversions of n sample clocks plus ten three-cycle trials each
  task automatic timeChk(input string nm, input int k, input int n);
    int el;
    el = irqAt - tW;
    chk(nm, 32'(el >= k * (n + 30) - 1 && el <= k * (n + 31) + 2), 32'h00000001);
  endtask

  task automatic pulse(input int i);
    @(posedge clock);
    timerTrig <= 4'(1 << i);
    @(posedge clock);
    timerTrig <= 4'h0;
  endtask
  // --------
  // sequence
  // --------
  initial
  begin
    int n;
    int b;
    void'($urandom(25));
    repeat (16) @(posedge clock);
    resetn <= 1'b1;
    rc("mode0", `ADSC_OFF_MODE0, 32'h00000000);
    rc("mode1", `ADSC_OFF_MODE1, 32'h00000007);
    apb(1'b0, 12'h040, 32'h00000000);
    chk("unmapped", 32'(rdErr), 32'h00000001);
    $display("test reset done");
    for (int c = 0; c < 8; c++)
    begin
      level[c] <= 10'($urandom);
      // every clock code; trigger code 1 on odd passes falls back to software start
      apb(1'b1, `ADSC_OFF_MODE1, 32'(c) | (c % 2 == 1 ? 32'h10 : 32'h00));
      b = irqCnt;
      apb(1'b1, `ADSC_OFF_MODE0, 32'h90 | 32'(c));
      rc("run busy", `ADSC_OFF_MODE0, 32'h90 | 32'(c));
      waitIrq(b + 1, 200);
      timeChk("conv time", 1, convLen(3'(c)));
      rc("run clear", `ADSC_OFF_MODE0, 32'h10 | 32'(c));
      resChk(c, c);
    end
    apb(1'b1, `ADSC_OFF_RES0, 32'(~level[0]));
    resChk(0, 0);
    $display("test select done");
    n = 1 + $urandom % 7;
    for (int c = 0; c < 8; c++) level[c] <= 10'($urandom);
    apb(1'b1, `ADSC_OFF_MODE1, 32'h00000000);
    b = irqCnt;
    apb(1'b1, `ADSC_OFF_MODE0, 32'h80 | 32'(n));
    waitIrq(b + 1, 400);
    timeChk("scan time", n + 1, 8);
    quiet(b + 1, 60);
    for (int c = 0; c <= n; c++) resChk(c, c);
    b = irqCnt;
    apb(1'b1, `ADSC_OFF_MODE0, 32'hB6);
    waitIrq(b + 1, 400);
    timeChk("buffer time", 4, 8);
    quiet(b + 1, 60);
    for (int c = 0; c < 4; c++) resChk(c, 6);
    $display("test scan done");
    apb(1'b1, `ADSC_OFF_MODE1, 32'h07);
    b = irqCnt;
    apb(1'b1, `ADSC_OFF_MODE0, 32'h92);
    repeat (60) @(posedge clock);
    apb(1'b1, `ADSC_OFF_MODE0, 32'h95);
    waitIrq(b + 1, 300);
    timeChk("restart time", 1, 128);
    resChk(5, 5);
    b = irqCnt;
    apb(1'b1, `ADSC_OFF_MODE0, 32'h91);
    repeat (60) @(posedge clock);
    apb(1'b1, `ADSC_OFF_MODE1, 32'h00);
    waitIrq(b + 1, 300);
    timeChk("mode1 restart", 1, 8);
    resChk(1, 1);
    apb(1'b1, `ADSC_OFF_MODE1, 32'h07);
    b = irqCnt;
    apb(1'b1, `ADSC_OFF_MODE0, 32'h93);
    repeat (20) @(posedge clock);
    apb(1'b1, `ADSC_OFF_MODE0, 32'h13);
    quiet(b, 250);
    rc("stopped", `ADSC_OFF_MODE0, 32'h13);
    $display("test abort done");
    apb(1'b1, `ADSC_OFF_MODE1, 32'h30);
    b = irqCnt;
    apb(1'b1, `ADSC_OFF_MODE0, 32'h03);
    rc("armed", `ADSC_OFF_MODE0, 32'h03);
    for (int j = 0; j < 4; j++)
    begin
      pulse((j * 3 + 2) % 4);
      rc("trig run", `ADSC_OFF_MODE0, 32'h83);
      repeat (45) @(posedge clock);
      chk("irq count", irqCnt, b + (j == 3 ? 1 : 0));
    end
    for (int c = 0; c < 4; c++) resChk(c, c);
    b = irqCnt;
    apb(1'b1, `ADSC_OFF_MODE0, 32'h95);
    waitIrq(b + 1, 100);
    timeChk("high input", 1, 8);
    apb(1'b1, `ADSC_OFF_MODE1, 32'h20);
    level[0] <= ~level[0];
    b = irqCnt;
    apb(1'b1, `ADSC_OFF_MODE0, 32'h10);
    pulse(1);
    quiet(b, 50);
    pulse(0);
    waitIrq(b + 1, 100);
    resChk(0, 0);
    $display("test timer done");
    apb(1'b1, `ADSC_OFF_MODE1, 32'hC0);
    b = irqCnt;
    apb(1'b1, `ADSC_OFF_MODE0, 32'h10);
    @(posedge clock);
    extConvTrig <= 4'hE;
    quiet(b, 50);
    extConvTrig <= 4'hF;
    waitIrq(b + 1, 100);
    apb(1'b1, `ADSC_OFF_MODE1, 32'h50);
    level[0] <= ~level[0];
    level[1] <= ~level[1];
    b = irqCnt;
    apb(1'b1, `ADSC_OFF_MODE0, 32'h01);
    @(posedge clock);
    extConvTrig <= 4'hD;
    quiet(b, 50);
    extConvTrig <= 4'hC;
    waitIrq(b + 1, 100);
    resChk(0, 0);
    resChk(1, 1);
    $display("test external done");
    close_out();
  end
endmodule
